// ---- logic/msbc_pkg.sv ----
package msbc_pkg;

  // operating modes, code = {mode_sel_hi, mode_sel_mid, mode_sel_lo}
  typedef enum logic [2:0] {
    MSBC_SPECIAL_SINGLE = 3'b000,
    MSBC_EMU_NARROW = 3'b001,
    MSBC_TEST_WIDE = 3'b010,
    MSBC_EMU_WIDE = 3'b011,
    MSBC_NORMAL_SINGLE = 3'b100,
    MSBC_NORMAL_NARROW = 3'b101,
    MSBC_SPECIAL_PERIPH = 3'b110,
    MSBC_NORMAL_WIDE = 3'b111
  } msbc_mode_e;

  // register byte offsets
  localparam logic [11:0] MSBC_OFS_MODE = 12'h000;
  localparam logic [11:0] MSBC_OFS_PORT_E_ASSIGN = 12'h004;
  localparam logic [11:0] MSBC_OFS_EXT_BUS_IF_CTRL = 12'h008;
  localparam logic [11:0] MSBC_OFS_STATUS = 12'h00C;

  // mode register fields
  localparam int MSBC_MODE_SEL_LSB = 5;
  localparam int MSBC_MODE_INTERNAL_VISIBILITY_BIT = 3;
  // port_e_assign fields, also the port E pin numbers they control
  localparam int MSBC_NO_ACCESS_EN_BIT = 7;
  localparam int MSBC_PIPE1_PIN = 6;
  localparam int MSBC_PIPE_STATUS_OUT_EN_BIT = 5;
  localparam int MSBC_BUS_CLOCK_OFF_BIT = 4;
  localparam int MSBC_LOW_STROBE_EN_BIT = 3;
  localparam int MSBC_READ_WRITE_PIN_EN_BIT = 2;
  localparam int MSBC_PIPE0_PIN = 5;
  localparam int MSBC_CLK_PIN = 4;
  localparam int MSBC_LOW_BYTE_STROBE_PIN = 3;
  localparam int MSBC_RW_PIN = 2;
  localparam int MSBC_NO_ACCESS_FLAG_PIN = 7;
  // ext_bus_if_ctrl fields
  localparam int MSBC_CLOCK_STRETCH_EN_BIT = 0;

  // port_e_assign reset values
  localparam logic [7:0] MSBC_PORT_E_ASSIGN_RST_SINGLE = 8'h10;
  localparam logic [7:0] MSBC_PORT_E_ASSIGN_RST_NORMAL_EXP = 8'h00;
  localparam logic [7:0] MSBC_PORT_E_ASSIGN_RST_EMU = 8'hAC;
  localparam logic [7:0] MSBC_PORT_E_ASSIGN_RST_SPM = 8'h00;
  localparam logic [7:0] MSBC_PORT_E_PULLUP_RST = 8'hFF;
  localparam logic [7:0] MSBC_ALL_INPUT = 8'hFF;

  // internal bus cycle presented by the core
  typedef struct packed {
    logic valid;
    logic data_phase;
    logic write;
    logic internal;
    logic map_ext;
    logic hi_byte;
    logic low_strobe_n;
    logic no_access;
    logic [1:0] pipe_status;
    logic [15:0] addr;
    logic [15:0] wdata;
  } msbc_bus_s;

  // pad controls for ports A, B and E
  typedef struct packed {
    logic [7:0] a_out;
    logic [7:0] a_oe_n;
    logic [7:0] b_out;
    logic [7:0] b_oe_n;
    logic [7:0] e_out;
    logic [7:0] e_oe_n;
    logic [7:0] e_pullup;
    logic ab_pullup;
  } msbc_pins_s;

  typedef struct packed {
    logic [2:0] mpin_meta;
    logic [2:0] mpin_sync;
    logic clk_meta;
    logic clk_sync;
    msbc_mode_e mode;
    logic internal_visibility;
    logic mode_wr_used;
    logic [7:0] port_e_assign;
    logic port_e_assign_wr_used;
    logic stretch;
    logic dbg_active;
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic [31:0] hrdata;
    msbc_pins_s pins;
  } msbc_state_s;

endpackage : msbc_pkg

// ---- logic/msbc_mode_bus_cfg.sv ----
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - mode select pins are latched into the mode bits when reset releases
// - codes 000..011 decode to special single, emulation narrow, test wide, emulation wide
// - codes 100..111 decode to normal single, normal narrow, special peripheral, normal wide
// - reset into any mode but special peripheral sets clock_stretch_en
// - debug is active at reset only in special single chip, else on command
// - normal single chip has no bus; ports A, B, E are inputs, E pulled up
// - single chip clears pipe, strobe, read/write enables; writing ones has no effect
// - normal single chip accepts one mode write to limited modes and visibility
// - clearing bus_clock_off drives a free-running bus clock on port E bit 4, except in special peripheral mode
// - normal wide uses ports A, B as 16-bit address/data, bus clock on E4
// - pipe_status_out_en puts pipe status on E6 and E5 in expanded modes
// - read_write_pin_en makes E2 the read/write output; software sets it first
// - in normal wide E3 is an input until low_strobe_en makes it the strobe
// - bus clock starts stretched; bus_clock_off, visibility and stretch govern it
// - normal narrow carries address on A and B, data on A only unless map_ext is set
// - internal visibility is never offered in normal narrow mode
// - normal narrow accepts one port_e_assign write; software sets all bits
// - in normal narrow E3 stays general purpose despite low_strobe_en
// - emulation modes drive all port E control pins; their enables are locked
// - emulation narrow uses 16-bit data for mapped internal registers, bytes externally
// - narrow pins: A15/D15/D7 on A7, A0 on B0, D8/D0 on A0
// - emulation narrow shows internal cycles as 16-bit only with visibility on or map_ext set
// - hidden internal access holds clock low while stretch is set, read/write high, bus and strobe unchanged
module msbc_mode_bus_cfg (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // mode pins and link clock source, asynchronous
  input wire logic i_mode_sel_hi,
  input wire logic i_mode_sel_mid,
  input wire logic i_mode_sel_lo,
  input wire logic i_bus_clk_src,
  // core side
  input wire msbc_pkg::msbc_bus_s i_bus,
  input wire logic i_debug_activate,
  output logic o_debug_active,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // pads
  output msbc_pkg::msbc_pins_s o_pins
);
  import msbc_pkg::*;

  msbc_state_s st;
  msbc_state_s next_st;
  logic single_chip;
  logic expanded;
  logic narrow;
  logic emulation;
  logic internal_visibility_eff;
  logic hide;
  logic wide_data;
  logic pipe_en;
  logic low_byte_strobe_en;
  logic rw_en;
  logic no_access_flag_en;
  logic clk_en;
  logic [2:0] wr_mode;

  function automatic logic f_single(input msbc_mode_e m);
    return m == MSBC_SPECIAL_SINGLE || m == MSBC_NORMAL_SINGLE;
  endfunction : f_single

  function automatic logic f_emulation(input msbc_mode_e m);
    return m == MSBC_EMU_NARROW || m == MSBC_EMU_WIDE;
  endfunction : f_emulation

  function automatic logic [7:0] f_port_e_assign_reset(input msbc_mode_e m);
    if (f_single(m)) begin
      return MSBC_PORT_E_ASSIGN_RST_SINGLE;
    end
    if (f_emulation(m)) begin
      return MSBC_PORT_E_ASSIGN_RST_EMU;
    end
    if (m == MSBC_SPECIAL_PERIPH) begin
      return MSBC_PORT_E_ASSIGN_RST_SPM;
    end
    return MSBC_PORT_E_ASSIGN_RST_NORMAL_EXP;
  endfunction : f_port_e_assign_reset

  // effective configuration from the stored bits and the mode
  always_comb begin
    single_chip = f_single(st.mode);
    emulation = f_emulation(st.mode);
    narrow = st.mode == MSBC_NORMAL_NARROW || st.mode == MSBC_EMU_NARROW;
    expanded = !single_chip && st.mode != MSBC_SPECIAL_PERIPH;
    internal_visibility_eff = st.internal_visibility && expanded && st.mode != MSBC_NORMAL_NARROW;
    pipe_en = st.port_e_assign[MSBC_PIPE_STATUS_OUT_EN_BIT] && expanded;
    low_byte_strobe_en = st.port_e_assign[MSBC_LOW_STROBE_EN_BIT] && expanded && st.mode != MSBC_NORMAL_NARROW;
    rw_en = st.port_e_assign[MSBC_READ_WRITE_PIN_EN_BIT] && expanded;
    no_access_flag_en = st.port_e_assign[MSBC_NO_ACCESS_EN_BIT] && expanded;
    clk_en = !st.port_e_assign[MSBC_BUS_CLOCK_OFF_BIT] && st.mode != MSBC_SPECIAL_PERIPH;
    hide = i_bus.valid && i_bus.internal && !internal_visibility_eff && !i_bus.map_ext;
    // 16-bit data on A and B unless a narrow external access
    wide_data = !narrow || i_bus.map_ext || (i_bus.internal && internal_visibility_eff);
  end

  always_comb begin
    next_st = st;
    wr_mode = i_hwdata[MSBC_MODE_SEL_LSB +: 3];
    next_st.mpin_meta = {i_mode_sel_hi, i_mode_sel_mid, i_mode_sel_lo};
    next_st.mpin_sync = st.mpin_meta;
    next_st.clk_meta = i_bus_clk_src;
    next_st.clk_sync = st.clk_meta;

    // AHB data phase: writes take effect here
    if (st.ph_valid && st.ph_write) begin
      unique case (st.ph_addr)
        MSBC_OFS_MODE: begin
          if (st.mode == MSBC_NORMAL_SINGLE && !st.mode_wr_used) begin
            next_st.mode_wr_used = 1'b1;
            next_st.internal_visibility = i_hwdata[MSBC_MODE_INTERNAL_VISIBILITY_BIT];
            if (wr_mode == MSBC_SPECIAL_SINGLE || wr_mode == MSBC_NORMAL_WIDE || wr_mode == MSBC_NORMAL_NARROW) begin
              next_st.mode = msbc_mode_e'(wr_mode);
            end
          end else if (st.mode == MSBC_SPECIAL_SINGLE || st.mode == MSBC_TEST_WIDE) begin
            // special single and test wide may switch freely, but never into peripheral mode
            next_st.internal_visibility = i_hwdata[MSBC_MODE_INTERNAL_VISIBILITY_BIT];
            if (wr_mode != MSBC_SPECIAL_PERIPH) begin
              next_st.mode = msbc_mode_e'(wr_mode);
            end
          end else if (st.mode != MSBC_SPECIAL_PERIPH && st.mode != MSBC_NORMAL_SINGLE) begin
            next_st.internal_visibility = i_hwdata[MSBC_MODE_INTERNAL_VISIBILITY_BIT];
          end
        end
        MSBC_OFS_PORT_E_ASSIGN: begin
          if (emulation) begin
            next_st.port_e_assign = st.port_e_assign;
          end else if (st.mode == MSBC_NORMAL_NARROW) begin
            if (!st.port_e_assign_wr_used) begin
              next_st.port_e_assign = i_hwdata[7:0];
              next_st.port_e_assign_wr_used = 1'b1;
            end
          end else if (st.mode != MSBC_SPECIAL_PERIPH) begin
            next_st.port_e_assign = i_hwdata[7:0];
          end
        end
        MSBC_OFS_EXT_BUS_IF_CTRL: begin
          if (st.mode != MSBC_SPECIAL_PERIPH) begin
            next_st.stretch = i_hwdata[MSBC_CLOCK_STRETCH_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // AHB address phase
    next_st.ph_valid = i_hsel && i_hready && i_htrans[1];
    next_st.ph_write = i_hwrite;
    next_st.ph_addr = (i_haddr[31:12] == 20'h00000) ? i_haddr[11:0] : 12'hFFF;
    next_st.hrdata = 32'h00000000;
    if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
      if (i_haddr[31:12] == 20'h00000) begin
        unique case (i_haddr[11:0])
          MSBC_OFS_MODE: begin
            next_st.hrdata[MSBC_MODE_SEL_LSB +: 3] = st.mode;
            next_st.hrdata[MSBC_MODE_INTERNAL_VISIBILITY_BIT] = st.internal_visibility;
          end
          MSBC_OFS_PORT_E_ASSIGN: next_st.hrdata[7:0] = st.port_e_assign;
          MSBC_OFS_EXT_BUS_IF_CTRL: next_st.hrdata[MSBC_CLOCK_STRETCH_EN_BIT] = st.stretch;
          MSBC_OFS_STATUS: next_st.hrdata[5:0] = {internal_visibility_eff, st.port_e_assign_wr_used, st.mode_wr_used, narrow,
                                                  expanded, st.dbg_active};
          default: begin
          end
        endcase
      end
    end

    // background debug activation by serial command
    if (i_debug_activate) begin
      next_st.dbg_active = 1'b1;
    end

    // port E: general purpose pins are pulled-up inputs
    next_st.pins.e_oe_n = MSBC_ALL_INPUT;
    next_st.pins.e_pullup = MSBC_PORT_E_PULLUP_RST;
    next_st.pins.ab_pullup = 1'b0;
    if (clk_en) begin
      next_st.pins.e_oe_n[MSBC_CLK_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_CLK_PIN] = 1'b0;
      // stretch makes the clock a bus control signal that idles low on hidden cycles
      next_st.pins.e_out[MSBC_CLK_PIN] = (st.stretch && expanded && hide) ? 1'b0 : st.clk_sync;
    end
    if (rw_en) begin
      next_st.pins.e_oe_n[MSBC_RW_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_RW_PIN] = 1'b0;
      next_st.pins.e_out[MSBC_RW_PIN] = !(i_bus.valid && !hide && i_bus.write);
    end
    if (low_byte_strobe_en) begin
      next_st.pins.e_oe_n[MSBC_LOW_BYTE_STROBE_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_LOW_BYTE_STROBE_PIN] = 1'b0;
      if (i_bus.valid && !hide) begin
        next_st.pins.e_out[MSBC_LOW_BYTE_STROBE_PIN] = i_bus.low_strobe_n;
      end
    end
    if (pipe_en) begin
      next_st.pins.e_oe_n[MSBC_PIPE1_PIN] = 1'b0;
      next_st.pins.e_oe_n[MSBC_PIPE0_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_PIPE1_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_PIPE0_PIN] = 1'b0;
      next_st.pins.e_out[MSBC_PIPE1_PIN] = i_bus.pipe_status[1];
      next_st.pins.e_out[MSBC_PIPE0_PIN] = i_bus.pipe_status[0];
    end
    if (no_access_flag_en) begin
      next_st.pins.e_oe_n[MSBC_NO_ACCESS_FLAG_PIN] = 1'b0;
      next_st.pins.e_pullup[MSBC_NO_ACCESS_FLAG_PIN] = 1'b0;
      next_st.pins.e_out[MSBC_NO_ACCESS_FLAG_PIN] = i_bus.no_access;
    end

    // ports A and B: inputs without pull-ups unless expanded
    if (!expanded) begin
      next_st.pins.a_oe_n = MSBC_ALL_INPUT;
      next_st.pins.b_oe_n = MSBC_ALL_INPUT;
    end else if (i_bus.valid && !hide) begin
      if (!i_bus.data_phase) begin
        // address phase: A15 on A7 down to A0 on B0
        next_st.pins.a_oe_n = 8'h00;
        next_st.pins.b_oe_n = 8'h00;
        next_st.pins.a_out = i_bus.addr[15:8];
        next_st.pins.b_out = i_bus.addr[7:0];
      end else if (wide_data) begin
        next_st.pins.a_oe_n = i_bus.write ? 8'h00 : MSBC_ALL_INPUT;
        next_st.pins.b_oe_n = i_bus.write ? 8'h00 : MSBC_ALL_INPUT;
        next_st.pins.a_out = i_bus.wdata[15:8];
        next_st.pins.b_out = i_bus.wdata[7:0];
      end else begin
        // narrow external: byte on port A only, B keeps the address
        next_st.pins.a_oe_n = i_bus.write ? 8'h00 : MSBC_ALL_INPUT;
        next_st.pins.a_out = i_bus.hi_byte ? i_bus.wdata[15:8] : i_bus.wdata[7:0];
      end
    end

    // reset: mode pins sampled every cycle, so the value at release is kept
    if (i_srst) begin
      next_st.mode = msbc_mode_e'(st.mpin_sync);
      next_st.internal_visibility = 1'b0;
      next_st.mode_wr_used = 1'b0;
      next_st.port_e_assign = f_port_e_assign_reset(msbc_mode_e'(st.mpin_sync));
      next_st.port_e_assign_wr_used = 1'b0;
      next_st.stretch = msbc_mode_e'(st.mpin_sync) != MSBC_SPECIAL_PERIPH;
      next_st.dbg_active = msbc_mode_e'(st.mpin_sync) == MSBC_SPECIAL_SINGLE;
      next_st.ph_valid = 1'b0;
      next_st.hrdata = 32'h00000000;
      next_st.pins.a_out = 8'h00;
      next_st.pins.b_out = 8'h00;
      next_st.pins.e_out = 8'h00;
      next_st.pins.a_oe_n = MSBC_ALL_INPUT;
      next_st.pins.b_oe_n = MSBC_ALL_INPUT;
      next_st.pins.e_oe_n = MSBC_ALL_INPUT;
      next_st.pins.e_pullup = MSBC_PORT_E_PULLUP_RST;
      next_st.pins.ab_pullup = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    st <= next_st;
  end

  // zero wait states, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = st.hrdata;
  assign o_pins = st.pins;
  assign o_debug_active = st.dbg_active;

  a_mode_latch: assert property (@(posedge i_sys_clk)
    $fell(i_srst) |-> st.mode == $past(st.mpin_sync, 2))
    else $error("mode not latched at reset release");

  a_stretch_rst: assert property (@(posedge i_sys_clk)
    $fell(i_srst) |-> st.stretch == (st.mode != MSBC_SPECIAL_PERIPH))
    else $error("stretch reset value wrong");

  a_single_ctrl: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    f_single(st.mode) ##1 f_single(st.mode) |-> o_pins.e_oe_n[MSBC_PIPE1_PIN] && o_pins.e_oe_n[MSBC_PIPE0_PIN]
      && o_pins.e_oe_n[MSBC_LOW_BYTE_STROBE_PIN] && o_pins.e_oe_n[MSBC_RW_PIN])
    else $error("single chip drives a bus control pin");

  a_single_ab: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    f_single(st.mode) ##1 f_single(st.mode) |-> o_pins.a_oe_n == 8'hFF && o_pins.b_oe_n == 8'hFF)
    else $error("single chip drives ports A or B");

  a_mode_once: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st.mode_wr_used && $past(st.mode_wr_used) && $past(st.mode) == MSBC_NORMAL_SINGLE
      |-> st.mode == MSBC_NORMAL_SINGLE || $past(st.mode_wr_used, 2))
    else $error("mode changed by a second write");

  a_narrow_port_e_assign: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st.mode == MSBC_NORMAL_NARROW && st.port_e_assign_wr_used ##1 st.mode == MSBC_NORMAL_NARROW
      |-> $stable(st.port_e_assign))
    else $error("port_e_assign written twice in narrow mode");

  a_narrow_strobe: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st.mode == MSBC_NORMAL_NARROW ##1 st.mode == MSBC_NORMAL_NARROW |-> o_pins.e_oe_n[MSBC_LOW_BYTE_STROBE_PIN])
    else $error("strobe driven in narrow mode");

  a_emu_locked: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    emulation && $past(emulation) && !$past(i_srst) |-> st.port_e_assign == MSBC_PORT_E_ASSIGN_RST_EMU)
    else $error("emulation enables changed");

  a_hidden_cycle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    hide && rw_en && clk_en && st.stretch && expanded ##1 !i_srst
      |-> o_pins.e_out[MSBC_RW_PIN] && !o_pins.e_out[MSBC_CLK_PIN] && $stable(o_pins.a_out))
    else $error("hidden internal cycle leaked to pins");

  a_no_internal_visibility_narrow: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    st.mode == MSBC_NORMAL_NARROW |-> !internal_visibility_eff)
    else $error("visibility in normal narrow mode");

  a_debug_cmd: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    i_debug_activate |=> o_debug_active [*2])
    else $error("debug command did not activate");

  c_mode_switch: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    st.mode == MSBC_NORMAL_SINGLE ##1 st.mode == MSBC_NORMAL_WIDE);
  c_narrow_byte: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    narrow && i_bus.valid && i_bus.data_phase && !wide_data);
  c_hidden: cover property (@(posedge i_sys_clk) disable iff (i_srst) hide && expanded);
  c_clock_free: cover property (@(posedge i_sys_clk) disable iff (i_srst)
    single_chip && clk_en);

endmodule : msbc_mode_bus_cfg

// ---- verification/msbc_ext_mem.sv ----
`timescale 1ns/1ps
// 16-bit wide external ram on the multiplexed bus; passive, the design has no read-back path
module msbc_ext_mem (
  // clock
  input wire logic i_sys_clk,
  // pads as seen from the board
  input wire msbc_pkg::msbc_pins_s i_pins,
  // last stored word and write count
  output logic [15:0] o_last_wr,
  output logic [7:0] o_wr_cnt
);
  import msbc_pkg::*;
  logic rw_low;
  // an undriven read/write line floats high on the board pull-up, so no stray writes
  assign rw_low = !i_pins.e_oe_n[MSBC_RW_PIN] && !i_pins.e_out[MSBC_RW_PIN];
  initial begin
    o_last_wr = 16'h0000;
    o_wr_cnt = 8'h00;
  end
  always @(posedge i_sys_clk) begin
    if (rw_low) begin
      o_last_wr <= {i_pins.a_out, i_pins.b_out};
      o_wr_cnt <= o_wr_cnt + 8'h01;
    end
  end
endmodule : msbc_ext_mem

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import msbc_pkg::*;
  logic i_sys_clk, i_srst, m_hi, m_mid, m_lo, clk_src, dbg_act, dbg_on;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize, mc;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] ad, wd, last_wr;
  logic [7:0] wr_cnt;
  msbc_bus_s bus;
  msbc_pins_s pins;
  int error_cnt, n_checks, tgl;

  msbc_mode_bus_cfg uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_mode_sel_hi(m_hi),
    .i_mode_sel_mid(m_mid), .i_mode_sel_lo(m_lo), .i_bus_clk_src(clk_src), .i_bus(bus),
    .i_debug_activate(dbg_act), .o_debug_active(dbg_on), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .o_pins(pins));
  msbc_ext_mem ext (.i_sys_clk(i_sys_clk), .i_pins(pins), .o_last_wr(last_wr), .o_wr_cnt(wr_cnt));

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // link clock source, unrelated in phase to the system clock
  initial begin
    clk_src = 1'b0;
    #7;
    forever #40 clk_src = ~clk_src;
  end

  task complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] port_e_assign_rst(input logic [2:0] m);
    case (m)
      3'b000, 3'b100: return 8'h10;
      3'b001, 3'b011: return 8'hAC;
      default: return 8'h00;
    endcase
  endfunction : port_e_assign_rst

  // {narrow, expanded, debug active}
  function automatic logic [2:0] exp_st(input logic [2:0] m);
    return {m[0] & ~m[1], (m != 3'b000) && (m != 3'b100) && (m != 3'b110), m == 3'b000};
  endfunction : exp_st

  task do_reset(input logic [2:0] m);
    {m_hi, m_mid, m_lo} <= m;
    i_srst <= 1'b1;
    bus <= '0;
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
  endtask : do_reset

  // one single word transfer, idle cycle after it so reads see the last write
  task ahb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge i_sys_clk);
    while (hreadyout !== 1'b1) @(posedge i_sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge i_sys_clk);
    while (hreadyout !== 1'b1) @(posedge i_sys_clk);
    rd = hrdata;
    chk(32'(hresp), 32'h0, "response");
    @(posedge i_sys_clk);
  endtask : ahb

  // core write cycle; pins lag one clock, data phase is left standing afterwards
  task xfer(input logic intl, mx, hb, input logic [15:0] a, d, ea, ed, input logic erw);
    bus <= {1'b1, 1'b0, 1'b1, intl, mx, hb, 1'b1, 1'b0, a[1:0], a, d};
    @(posedge i_sys_clk);
    bus <= {1'b1, 1'b1, 1'b1, intl, mx, hb, 1'b1, 1'b0, a[1:0], a, d};
    @(negedge i_sys_clk);
    chk(32'({pins.a_out, pins.b_out}), 32'(ea), "address phase");
    if (pins.e_oe_n[6] === 1'b0 && !intl) chk(32'(pins.e_out[6:5]), 32'(a[1:0]), "pipe");
    if (intl && !mx) chk(32'(pins.e_out[4]), 32'h0, "clock held");
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk(32'({pins.a_out, pins.b_out}), 32'(ed), "data phase");
    chk(32'(pins.e_out[2]), 32'(erw), "read write line");
    if (intl && !mx) chk(32'(pins.e_out[4]), 32'h0, "clock held");
    @(posedge i_sys_clk);
  endtask : xfer

  initial begin
    repeat (50000) @(posedge i_sys_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    i_srst = 1'b1;
    {m_hi, m_mid, m_lo} = 3'b100;
    bus = '0;
    dbg_act = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(48604));
    for (int m = 0; m < 8; m++) begin
      mc = m[2:0];
      do_reset(mc);
      ahb(1'b0, MSBC_OFS_MODE, 8'h00);
      chk(32'(rd[7:5]), 32'(mc), "mode bits");
      ahb(1'b0, MSBC_OFS_STATUS, 8'h00);
      chk(32'(rd[2:0]), 32'(exp_st(mc)), "mode decode");
      chk(32'(dbg_on), 32'(mc == 3'b000), "debug at reset");
      ahb(1'b0, MSBC_OFS_EXT_BUS_IF_CTRL, 8'h00);
      chk(32'(rd[0]), 32'(mc != 3'b110), "stretch");
      ahb(1'b0, MSBC_OFS_PORT_E_ASSIGN, 8'h00);
      chk(32'(rd[7:0]), 32'(port_e_assign_rst(mc)), "assign reset");
      if (mc == 3'b100) begin
        chk({pins.a_oe_n, pins.b_oe_n, pins.e_oe_n, pins.e_pullup}, 32'hFFFFFFFF, "pads");
        chk(32'(pins.ab_pullup), 32'h0, "ab pullup");
      end
      if (mc[2] && mc[0]) chk(32'(pins.e_oe_n), 32'h000000EF, "expanded port e");
      if (!mc[2] && mc[0]) chk(32'(pins.e_oe_n[7:2]), 32'h0, "emulation controls");
    end
    // normal single chip: debug on command, locked pins, free clock, one mode write
    do_reset(3'b100);
    dbg_act <= 1'b1;
    @(posedge i_sys_clk);
    dbg_act <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(dbg_on), 32'h1, "debug on command");
    ahb(1'b1, MSBC_OFS_PORT_E_ASSIGN, 8'h2C);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(pins.e_oe_n), 32'h000000EF, "single chip port e");
    tgl = 0;
    @(negedge i_sys_clk);
    ad[0] = pins.e_out[4];
    repeat (60) begin
      @(negedge i_sys_clk);
      if (pins.e_out[4] !== ad[0]) tgl++;
      ad[0] = pins.e_out[4];
    end
    chk(32'(tgl >= 4), 32'h1, "free bus clock");
    ahb(1'b0, 12'h010, 8'h00);
    chk(rd, 32'h0, "unmapped read");
    ahb(1'b1, MSBC_OFS_MODE, 8'hE8);
    ahb(1'b1, MSBC_OFS_MODE, 8'h80);
    ahb(1'b0, MSBC_OFS_MODE, 8'h00);
    chk(32'(rd[7:5]), 32'h7, "one mode write");
    // normal wide: control pins on request, random writes, hidden internal cycle
    do_reset(3'b111);
    chk(32'(pins.e_oe_n[3]), 32'h1, "strobe default input");
    ahb(1'b1, MSBC_OFS_PORT_E_ASSIGN, 8'h2C);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(pins.e_oe_n[6:2]), 32'h0, "wide controls");
    for (int k = 0; k < 4; k++) begin
      ad = (k == 0) ? 16'h0000 : 16'($urandom);
      wd = (k == 0) ? 16'hFFFF : 16'($urandom);
      xfer(1'b0, 1'b0, 1'b0, ad, wd, ad, wd, 1'b0);
      @(posedge i_sys_clk);
      chk(32'(last_wr), 32'(wd), "stored word");
    end
    chk(32'(wr_cnt != 8'h00), 32'h1, "writes seen");
    xfer(1'b1, 1'b0, 1'b0, ~ad, ~wd, wd, wd, 1'b1);
    // normal narrow: single assign write, strobe overridden, no visibility
    do_reset(3'b101);
    ahb(1'b1, MSBC_OFS_PORT_E_ASSIGN, 8'h2C);
    ahb(1'b1, MSBC_OFS_PORT_E_ASSIGN, 8'h00);
    ahb(1'b0, MSBC_OFS_PORT_E_ASSIGN, 8'h00);
    chk(32'(rd[7:0]), 32'h2C, "one assign write");
    chk(32'({pins.e_oe_n[3], pins.e_oe_n[2]}), 32'h2, "narrow strobe and rw");
    ahb(1'b1, MSBC_OFS_MODE, 8'hA8);
    ahb(1'b0, MSBC_OFS_STATUS, 8'h00);
    chk(32'(rd[5]), 32'h0, "narrow visibility");
    ad = 16'($urandom);
    wd = 16'($urandom);
    xfer(1'b0, 1'b0, 1'b1, ad, wd, ad, {wd[15:8], ad[7:0]}, 1'b0);
    xfer(1'b0, 1'b0, 1'b0, ad, wd, ad, {wd[7:0], ad[7:0]}, 1'b0);
    // emulation narrow: locked enables, mapped registers 16 bits wide, hidden cycle
    do_reset(3'b001);
    ahb(1'b1, MSBC_OFS_PORT_E_ASSIGN, 8'h00);
    ahb(1'b0, MSBC_OFS_PORT_E_ASSIGN, 8'h00);
    chk(32'(rd[7:0]), 32'hAC, "emulation enables locked");
    xfer(1'b1, 1'b1, 1'b0, ad, wd, ad, wd, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, ~ad, ~wd, wd, wd, 1'b1);
    complete_run();
  end
endmodule : tb_top
